// ===== hdl/psram_pkg.sv
// shared constants, field layouts and state codes for the muxed pseudo-static ram bus interface
//
// Overview of operation
// - self-initialize for power-up delay, load default configuration
// - async read: address on adv rise, data after access
// - async write: address on adv rise, then data
// - write strobe overrides output enable in writes
// - write data latched on first rising control edge
// - burst: address and direction on first clock edge
// - burst length four, eight, sixteen, thirty-two, continuous
// - continuous burst wraps from last to first address
// - latency count sets clocks before first word
// - fixed latency covers worst case including refresh
// - wait asserted at start, released when data moves
// - row boundary reasserts wait, then burst continues
// - variable latency refresh collision extends wait
// - wait driven in async reads, floated in async writes
// - async writes accepted while configured for bursts
// - deselected bytes unchanged; both high disables data bus
// - configuration bit fifteen selects burst or async mode
// - configuration bit ten selects wait polarity
// - low select enables lanes 7:0, high 15:8
package psram_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int POWERUP_DELAY_NS = 150_000;
	localparam int POWERUP_CYCLES = (POWERUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POWERUP_CNT_W = 11;
	localparam int PIN_W = 29;
	localparam int BCR_MODE_BIT = 15;
	localparam int BCR_FIXLAT_BIT = 14;
	localparam int BCR_LAT_HI = 13;
	localparam int BCR_LAT_LO = 11;
	localparam int BCR_WAITPOL_BIT = 10;
	localparam int BCR_NOWRAP_BIT = 3;
	localparam int BCR_BL_HI = 2;
	localparam logic [15:0] BCR_RESET = 16'h9D1F;
	localparam logic [15:0] RCR_RESET = 16'h0010;
	localparam logic [2:0] BL_4 = 3'h1;
	localparam logic [2:0] BL_8 = 3'h2;
	localparam logic [2:0] BL_16 = 3'h3;
	localparam logic [2:0] BL_32 = 3'h4;
	localparam logic [1:0] REG_IDX_BCR = 2'h0;
	localparam logic [1:0] REG_IDX_RCR = 2'h1;
	localparam logic [1:0] REG_IDX_STATUS = 2'h2;
	typedef enum logic [2:0] {
		ST_INIT = 3'h0,
		ST_IDLE = 3'h1,
		ST_LAT = 3'h2,
		ST_DATA = 3'h3,
		ST_ROW = 3'h4,
		ST_DONE = 3'h5
	} state_t;
endpackage : psram_pkg

// ===== hdl/psram_bus_if.sv
// device-side bus interface of a muxed address/data pseudo-static ram
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module psram_bus_if import psram_pkg::*; #(
	parameter int MEM_AW = 22,
	parameter int ACCESS_CYCLES = 1,
	parameter int ROW_WORDS = 128,
	parameter int ROW_WAIT_CLKS = 3,
	parameter int REFRESH_INTERVAL = 156,
	parameter int REFRESH_LEN = 4
) (
	input wire logic CLOCK_I,
	input wire logic RST_I,
	input wire logic BUS_CLK_I,
	input wire logic CHIP_SELECT_N_I,
	input wire logic ADDR_VALID_N_I,
	input wire logic OUTPUT_EN_N_I,
	input wire logic WRITE_STROBE_N_I,
	input wire logic HIGH_BYTE_SEL_N_I,
	input wire logic LOW_BYTE_SEL_N_I,
	input wire logic [5:0] ADDR_HI_I,
	input wire logic [15:0] AD_I,
	output logic [15:0] AD_O,
	output logic [1:0] AD_OE_O,
	output logic WAIT_O,
	output logic WAIT_OE_O,
	output logic READY_O,
	input wire logic [1:0] REG_ADDR_I,
	input wire logic [15:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [15:0] REG_RDATA_O
);
	localparam int ROW_BITS = $clog2(ROW_WORDS);

	function automatic logic [5:0] burst_len(input logic [2:0] code);
		case (code)
			BL_4: burst_len = 6'h04;
			BL_8: burst_len = 6'h08;
			BL_16: burst_len = 6'h10;
			BL_32: burst_len = 6'h20;
			default: burst_len = 6'h00;
		endcase
	endfunction : burst_len

	// wrap keeps the high part and rolls only the bits inside the burst block
	function automatic logic [MEM_AW-1:0] next_addr(input logic [MEM_AW-1:0] a,
			input logic [5:0] len, input logic wrap_on);
		logic [MEM_AW-1:0] inc;
		logic [MEM_AW-1:0] mask;
		inc = a + 1'b1;
		mask = MEM_AW'(len) - 1'b1;
		if (wrap_on && len != 6'h00)
			next_addr = (a & ~mask) | (inc & mask);
		else
			next_addr = inc;
	endfunction : next_addr

	logic [PIN_W-1:0] pin_s1_r;
	logic [PIN_W-1:0] pin_s2_r;
	logic [PIN_W-1:0] pin_p_r;
	logic bclk, cs_n, adv_n, oe_n, we_n, ub_n, lb_n;
	logic p_bclk, p_cs_n, p_adv_n, p_we_n, p_ub_n, p_lb_n;
	logic [15:0] ad;
	logic [15:0] p_ad;
	logic [21:0] full_addr;
	logic [MEM_AW-1:0] addr_in;
	logic clk_rise;

	logic [15:0] mem [0:(2**MEM_AW)-1];
	logic [POWERUP_CNT_W-1:0] init_cnt_r;
	logic init_done_r;
	logic [15:0] bcr_r;
	logic [15:0] rcr_r;
	logic [15:0] ref_cnt_r;
	logic refresh_busy;
	state_t state_r;
	logic [5:0] lat_cnt_r;
	logic [5:0] left_r;
	logic [MEM_AW-1:0] burst_addr_r;
	logic is_write_r;
	logic [MEM_AW-1:0] async_addr_r;
	logic [7:0] acc_cnt_r;
	logic aw_done_r;
	logic burst_en, wrap_on, row_cross;
	logic [2:0] lat_code;
	logic [5:0] lat_first;
	logic [5:0] cur_len;
	logic [MEM_AW-1:0] nxt_burst;
	logic async_rd, acc_ok, async_wr_edge, burst_wr;
	logic drive, wait_act, wait_drv;
	logic wr_en;
	logic [MEM_AW-1:0] wr_addr;
	logic [15:0] wr_data;
	logic [1:0] wr_be;
	logic [15:0] rd_word_r;
	logic [1:0] ad_oe_r;
	logic wait_r, wait_oe_r;

	// every pin crosses two flops; edges are found between stage two and its delayed copy
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			pin_s1_r <= '1;
			pin_s2_r <= '1;
			pin_p_r <= '1;
		end else begin
			pin_s1_r <= {BUS_CLK_I, CHIP_SELECT_N_I, ADDR_VALID_N_I, OUTPUT_EN_N_I,
				WRITE_STROBE_N_I, HIGH_BYTE_SEL_N_I, LOW_BYTE_SEL_N_I, ADDR_HI_I, AD_I};
			pin_s2_r <= pin_s1_r;
			pin_p_r <= pin_s2_r;
		end
	end

	assign bclk = pin_s2_r[28];
	assign cs_n = pin_s2_r[27];
	assign adv_n = pin_s2_r[26];
	assign oe_n = pin_s2_r[25];
	assign we_n = pin_s2_r[24];
	assign ub_n = pin_s2_r[23];
	assign lb_n = pin_s2_r[22];
	assign full_addr = pin_s2_r[21:0];
	assign ad = pin_s2_r[15:0];
	assign addr_in = full_addr[MEM_AW-1:0];
	assign p_bclk = pin_p_r[28];
	assign p_cs_n = pin_p_r[27];
	assign p_adv_n = pin_p_r[26];
	assign p_we_n = pin_p_r[24];
	assign p_ub_n = pin_p_r[23];
	assign p_lb_n = pin_p_r[22];
	assign p_ad = pin_p_r[15:0];
	assign clk_rise = bclk & ~p_bclk;

	// power-up self-initialization; configuration already holds defaults from reset
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			init_cnt_r <= '0;
			init_done_r <= 1'b0;
		end else if (!init_done_r) begin
			if (init_cnt_r == POWERUP_CNT_W'(POWERUP_CYCLES - 1))
				init_done_r <= 1'b1;
			init_cnt_r <= init_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			bcr_r <= BCR_RESET;
			rcr_r <= RCR_RESET;
		end else if (REG_WR_I) begin
			if (REG_ADDR_I == REG_IDX_BCR)
				bcr_r <= REG_WDATA_I;
			if (REG_ADDR_I == REG_IDX_RCR)
				rcr_r <= REG_WDATA_I;
		end
	end

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			REG_RDATA_O <= 16'h0000;
		end else if (REG_RD_I) begin
			case (REG_ADDR_I)
				REG_IDX_BCR: REG_RDATA_O <= bcr_r;
				REG_IDX_RCR: REG_RDATA_O <= rcr_r;
				REG_IDX_STATUS: REG_RDATA_O <= {11'h000, refresh_busy, init_done_r, state_r};
				default: REG_RDATA_O <= 16'h0000;
			endcase
		end
	end

	// internal refresh slot, periodic; only a variable-latency read sees it
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			ref_cnt_r <= 16'h0000;
		end else if (ref_cnt_r == 16'(REFRESH_INTERVAL - 1)) begin
			ref_cnt_r <= 16'h0000;
		end else begin
			ref_cnt_r <= ref_cnt_r + 16'h0001;
		end
	end
	assign refresh_busy = ref_cnt_r < 16'(REFRESH_LEN);

	assign burst_en = ~bcr_r[BCR_MODE_BIT];
	assign cur_len = burst_len(bcr_r[BCR_BL_HI:0]);
	assign wrap_on = ~bcr_r[BCR_NOWRAP_BIT] && cur_len != 6'h00;
	assign lat_code = bcr_r[BCR_LAT_HI:BCR_LAT_LO];
	always_comb begin
		lat_first = {3'h0, lat_code} + 6'h01;
		// fixed latency already budgets the refresh, so only variable reads stretch
		if (we_n && !bcr_r[BCR_FIXLAT_BIT] && refresh_busy)
			lat_first = lat_first + {3'h0, lat_code};
	end
	assign nxt_burst = next_addr(burst_addr_r, cur_len, wrap_on);
	assign row_cross = !wrap_on && nxt_burst[ROW_BITS-1:0] == '0;

	// deselect ends any burst at once; host keeps its own timing around it
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			state_r <= ST_INIT;
			lat_cnt_r <= 6'h00;
			left_r <= 6'h00;
			burst_addr_r <= '0;
			is_write_r <= 1'b0;
		end else if (!init_done_r) begin
			state_r <= ST_INIT;
		end else if (cs_n || !burst_en) begin
			state_r <= ST_IDLE;
		end else if (clk_rise) begin
			case (state_r)
				ST_IDLE: begin
					if (!adv_n) begin
						burst_addr_r <= addr_in;
						is_write_r <= ~we_n;
						lat_cnt_r <= lat_first;
						left_r <= cur_len;
						state_r <= ST_LAT;
					end
				end
				ST_LAT, ST_ROW: begin
					if (lat_cnt_r == 6'h01)
						state_r <= ST_DATA;
					else
						lat_cnt_r <= lat_cnt_r - 6'h01;
				end
				ST_DATA: begin
					if (left_r == 6'h01) begin
						state_r <= ST_DONE;
					end else begin
						burst_addr_r <= nxt_burst;
						if (left_r != 6'h00)
							left_r <= left_r - 6'h01;
						if (row_cross) begin
							lat_cnt_r <= 6'(ROW_WAIT_CLKS);
							state_r <= ST_ROW;
						end
					end
				end
				ST_DONE: state_r <= ST_DONE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// async address follows the bus while adv is low; adv rising freezes it
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			async_addr_r <= '0;
		end else if (!cs_n && !adv_n) begin
			async_addr_r <= addr_in;
		end
	end

	assign async_rd = init_done_r && !cs_n && adv_n && !oe_n && we_n && state_r == ST_IDLE;
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			acc_cnt_r <= 8'h00;
		end else if (!async_rd) begin
			acc_cnt_r <= 8'h00;
		end else if (!acc_ok) begin
			acc_cnt_r <= acc_cnt_r + 8'h01;
		end
	end
	assign acc_ok = acc_cnt_r >= 8'(ACCESS_CYCLES);

	// only the first rising control edge writes; later edges are ignored until chip select rises or the write strobe falls again
	assign async_wr_edge = init_done_r && state_r == ST_IDLE && !aw_done_r && !p_cs_n
		&& !p_we_n && p_adv_n && ((cs_n && !p_cs_n) || (we_n && !p_we_n)
		|| (ub_n && !p_ub_n) || (lb_n && !p_lb_n));
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			aw_done_r <= 1'b0;
		end else if (async_wr_edge) begin
			aw_done_r <= 1'b1;
		end else if (cs_n || (p_we_n && !we_n)) begin
			aw_done_r <= 1'b0;
		end
	end

	assign burst_wr = init_done_r && burst_en && !cs_n && clk_rise && state_r == ST_DATA
		&& is_write_r;
	always_comb begin
		wr_en = 1'b0;
		wr_addr = burst_addr_r;
		wr_data = ad;
		wr_be = {~ub_n, ~lb_n};
		if (burst_wr) begin
			wr_en = 1'b1;
		end else if (async_wr_edge) begin
			wr_en = 1'b1;
			wr_addr = async_addr_r;
			wr_data = p_ad;
			wr_be = {~p_ub_n, ~p_lb_n};
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (wr_en && wr_be[0])
			mem[wr_addr][7:0] <= wr_data[7:0];
		if (wr_en && wr_be[1])
			mem[wr_addr][15:8] <= wr_data[15:8];
	end

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			rd_word_r <= 16'h0000;
		end else begin
			rd_word_r <= mem[state_r == ST_IDLE ? async_addr_r : burst_addr_r];
		end
	end

	// a write strobe low blocks the drivers even if output enable is low too
	assign drive = (async_rd && acc_ok) || (init_done_r && burst_en && !cs_n
		&& state_r == ST_DATA && !is_write_r && we_n);
	assign wait_act = state_r == ST_LAT || state_r == ST_ROW || (async_rd && !acc_ok);
	assign wait_drv = init_done_r && !cs_n && (async_rd
		|| (burst_en && state_r != ST_IDLE && state_r != ST_INIT));

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			ad_oe_r <= 2'h0;
			wait_r <= 1'b0;
			wait_oe_r <= 1'b0;
		end else begin
			ad_oe_r <= {drive && !ub_n, drive && !lb_n};
			wait_r <= wait_act ? bcr_r[BCR_WAITPOL_BIT] : ~bcr_r[BCR_WAITPOL_BIT];
			wait_oe_r <= wait_drv;
		end
	end

	assign AD_O = rd_word_r;
	assign AD_OE_O = ad_oe_r;
	assign WAIT_O = wait_r;
	assign WAIT_OE_O = wait_oe_r;
	assign READY_O = init_done_r;
endmodule : psram_bus_if
`default_nettype wire

// ===== sim/psram_bus_if_monitor.sv
// assertion checker for the psram bus interface, with its bind
`timescale 1ns/1ps
`default_nettype none
module psram_bus_if_monitor import psram_pkg::*; (
	input wire logic CLOCK_I,
	input wire logic RST_I,
	input wire logic CHIP_SELECT_N_I,
	input wire logic OUTPUT_EN_N_I,
	input wire logic WRITE_STROBE_N_I,
	input wire logic HIGH_BYTE_SEL_N_I,
	input wire logic LOW_BYTE_SEL_N_I,
	input wire logic [1:0] AD_OE_O,
	input wire logic WAIT_O,
	input wire logic WAIT_OE_O,
	input wire logic READY_O,
	input wire logic [1:0] REG_ADDR_I,
	input wire logic [15:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [15:0] REG_RDATA_O
);
	logic [15:0] bcr_r;
	logic [10:0] cnt_r;
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I)
			bcr_r <= BCR_RESET;
		else if (REG_WR_I && REG_ADDR_I == REG_IDX_BCR)
			bcr_r <= REG_WDATA_I;
	end
	// saturates so the late readiness check keeps holding
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I)
			cnt_r <= '0;
		else if (cnt_r != 11'h7FF)
			cnt_r <= cnt_r + 11'h001;
	end
	ready_early_a: assert property (cnt_r < 11'h5D2 |-> !READY_O)
		else $error("ready too early");
	ready_late_a: assert property (cnt_r > 11'h5E6 |-> READY_O)
		else $error("ready too late");
	init_quiet_a: assert property (!READY_O |-> AD_OE_O == 2'h0 && !WAIT_OE_O)
		else $error("pins driven during init");
	deselect_float_a: assert property (CHIP_SELECT_N_I [*4] |-> AD_OE_O == 2'h0)
		else $error("bus driven while deselected");
	write_priority_a: assert property ((!WRITE_STROBE_N_I) [*4] |-> AD_OE_O == 2'h0)
		else $error("bus driven during write");
	upper_lane_a: assert property (HIGH_BYTE_SEL_N_I [*4] |-> !AD_OE_O[1])
		else $error("upper lane driven");
	lower_lane_a: assert property (LOW_BYTE_SEL_N_I [*4] |-> !AD_OE_O[0])
		else $error("lower lane driven");
	async_oe_a: assert property ((bcr_r[15] && OUTPUT_EN_N_I) [*4] |-> AD_OE_O == 2'h0)
		else $error("async drive without enable");
	wait_float_a: assert property ((bcr_r[15] && !WRITE_STROBE_N_I) [*4] |-> !WAIT_OE_O)
		else $error("wait driven in write");
	read_wait_a: assert property ((!CHIP_SELECT_N_I && !OUTPUT_EN_N_I && WRITE_STROBE_N_I
		&& READY_O) [*6] |-> WAIT_OE_O)
		else $error("wait floated in read");
	wait_release_a: assert property ($rose(|AD_OE_O) |-> ##[0:1] WAIT_O == !bcr_r[10])
		else $error("wait active with data");
	reg_read_a: assert property (REG_RD_I && REG_ADDR_I == REG_IDX_BCR
		|=> REG_RDATA_O == $past(bcr_r))
		else $error("config readback wrong");
	burst_cv: cover property ($rose(|AD_OE_O) && !bcr_r[15]);
	async_cv: cover property ($rose(|AD_OE_O) && bcr_r[15]);
	regrd_cv: cover property (REG_RD_I && REG_ADDR_I == REG_IDX_BCR);
endmodule : psram_bus_if_monitor
bind psram_bus_if psram_bus_if_monitor psram_bus_if_monitor_inst (.CLOCK_I(CLOCK_I),
	.RST_I(RST_I), .CHIP_SELECT_N_I(CHIP_SELECT_N_I), .OUTPUT_EN_N_I(OUTPUT_EN_N_I),
	.WRITE_STROBE_N_I(WRITE_STROBE_N_I), .HIGH_BYTE_SEL_N_I(HIGH_BYTE_SEL_N_I),
	.LOW_BYTE_SEL_N_I(LOW_BYTE_SEL_N_I), .AD_OE_O(AD_OE_O), .WAIT_O(WAIT_O),
	.WAIT_OE_O(WAIT_OE_O), .READY_O(READY_O), .REG_ADDR_I(REG_ADDR_I),
	.REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
	.REG_RDATA_O(REG_RDATA_O));
`default_nettype wire

// ===== sim/psram_host.sv
// host partner: drives the muxed pins and makes the bus clock in frames
`timescale 1ns/1ps
`default_nettype none
module psram_host (
	input wire logic [15:0] ad_i,
	input wire logic [1:0] oe_i,
	input wire logic wt_i,
	output logic clk_o,
	output logic cs_n_o,
	output logic adv_n_o,
	output logic oe_n_o,
	output logic we_n_o,
	output logic hb_n_o,
	output logic lb_n_o,
	output logic [5:0] hi_o,
	output logic [15:0] bus_o
);
	logic [15:0] hd_r;
	logic drv_r;
	logic [15:0] got [0:3];
	// released lanes show inverted leftovers so stale data never matches
	assign bus_o = drv_r ? hd_r : {oe_i[1] ? ad_i[15:8] : ~hd_r[15:8],
		oe_i[0] ? ad_i[7:0] : ~hd_r[7:0]};
	initial begin
		{clk_o, drv_r, hd_r, hi_o} = '0;
		{cs_n_o, adv_n_o, oe_n_o, we_n_o, hb_n_o, lb_n_o} = 6'h3F;
	end
	task automatic async_wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] l);
		{cs_n_o, adv_n_o, we_n_o, hd_r, drv_r} = {3'h0, a, 1'b1};
		{hb_n_o, lb_n_o} = l;
		#400 adv_n_o = 1'b1;
		#400 hd_r = d;
		#400 we_n_o = 1'b1;
		#200 {cs_n_o, drv_r, hb_n_o, lb_n_o} = 4'hB;
		#400;
	endtask : async_wr
	task automatic async_rd(input logic [15:0] a, output logic [15:0] d);
		{cs_n_o, adv_n_o, hb_n_o, lb_n_o, hd_r, drv_r} = {4'h0, a, 1'b1};
		#400 adv_n_o = 1'b1;
		#400 {drv_r, oe_n_o} = 2'h0;
		#1000 d = bus_o;
		{cs_n_o, oe_n_o, hb_n_o, lb_n_o} = 4'hF;
		#400;
	endtask : async_rd
	task automatic burst_rd(input logic [15:0] a, input logic wp, output int f, output int l);
		int n;
		n = 0;
		f = 0;
		l = 0;
		{cs_n_o, adv_n_o, hb_n_o, lb_n_o, hd_r, drv_r} = {4'h0, a, 1'b1};
		#437 clk_o = 1'b1;
		#400 {clk_o, adv_n_o, drv_r} = 3'h2;
		for (int k = 1; k < 40 && n < 4; k++) begin
			#400 if (wt_i !== wp) begin
				got[n] = bus_o;
				n++;
				f = (f == 0) ? k : f;
				l = k;
			end
			clk_o = 1'b1;
			#400 clk_o = 1'b0;
		end
		{cs_n_o, hb_n_o, lb_n_o} = 3'h7;
		#800;
	endtask : burst_rd
endmodule : psram_host
`default_nettype wire

// ===== sim/muxed_psram_bus_interface_test.sv
// self-checking bench for the psram bus interface
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("Error %s exp %h got %h", nm, e, g); end end
module muxed_psram_bus_interface_test import psram_pkg::*; ;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic bclk, cs_n, adv_n, oe_n, we_n, hb_n, lb_n, wt, rdy;
	logic [5:0] ahi;
	logic [15:0] ad_i, ad_o, rdata, v, a, d;
	logic [15:0] exp [0:1023];
	logic [1:0] ad_oe, ln;
	int bad_count = 0;
	int cmp_count = 0;
	int first, last;
	integer seed = 32'h70ED095F;
	always #50 clk = ~clk;
	psram_bus_if #(.MEM_AW(10), .ROW_WORDS(8)) psram_bus_if_inst (.CLOCK_I(clk), .RST_I(rst),
		.BUS_CLK_I(bclk), .CHIP_SELECT_N_I(cs_n), .ADDR_VALID_N_I(adv_n), .OUTPUT_EN_N_I(oe_n),
		.WRITE_STROBE_N_I(we_n), .HIGH_BYTE_SEL_N_I(hb_n), .LOW_BYTE_SEL_N_I(lb_n),
		.ADDR_HI_I(ahi), .AD_I(ad_i), .AD_O(ad_o), .AD_OE_O(ad_oe), .WAIT_O(wt),
		.WAIT_OE_O(), .READY_O(rdy), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
		.REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(rdata));
	psram_host psram_host_inst (.ad_i(ad_o), .oe_i(ad_oe), .wt_i(wt), .clk_o(bclk),
		.cs_n_o(cs_n), .adv_n_o(adv_n), .oe_n_o(oe_n), .we_n_o(we_n), .hb_n_o(hb_n),
		.lb_n_o(lb_n), .hi_o(ahi), .bus_o(ad_i));
	function automatic logic [15:0] merge(input logic [15:0] o, n, input logic [1:0] l);
		return {l[1] ? o[15:8] : n[15:8], l[0] ? o[7:0] : n[7:0]};
	endfunction : merge
	task automatic reg_put(input logic [1:0] ra, input logic [15:0] rd);
		@(posedge clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, ra, rd};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_put
	task automatic reg_chk(input logic [1:0] ra, input logic [15:0] e);
		@(posedge clk);
		{reg_rd, reg_addr} <= {1'b1, ra};
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 `CHK("reg_rdata", e, rdata)
	endtask : reg_chk
	// async fill keeps the clock static, so it also covers mixed mode
	task automatic burst_chk(input logic [9:0] b, input logic [15:0] cfg, input logic wp);
		reg_put(REG_IDX_BCR, cfg);
		for (int i = 0; i < 4; i++) begin
			exp[b + 10'(i)] = 16'($random(seed));
			psram_host_inst.async_wr({6'h00, b + 10'(i)}, exp[b + 10'(i)], 2'h0);
		end
		psram_host_inst.burst_rd({6'h00, b}, wp, first, last);
		for (int i = 0; i < 4; i++)
			`CHK("burst_word", exp[b + 10'(i)], psram_host_inst.got[i])
	endtask : burst_chk
	task automatic test_done;
		if (bad_count == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done
	initial begin
		#5000000;
		bad_count++;
		test_done();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		reg_chk(REG_IDX_BCR, BCR_RESET);
		reg_chk(REG_IDX_RCR, RCR_RESET);
		v = 16'($random(seed));
		reg_put(REG_IDX_RCR, v);
		reg_chk(REG_IDX_RCR, v);
		reg_put(2'h3, v);
		reg_chk(2'h3, 16'h0000);
		for (int i = 0; i < 2000 && rdy !== 1'b1; i++)
			@(posedge clk);
		`CHK("ready", 1'b1, rdy)
		@(posedge clk);
		{reg_rd, reg_addr} <= {1'b1, REG_IDX_STATUS};
		@(posedge clk);
		reg_rd <= 1'b0;
		// refresh slot bit is free running, so it is masked out
		#1 `CHK("status", 16'h0009, rdata & 16'hFFEF)
		for (int i = 0; i < 6; i++) begin
			a = 16'($random(seed)) & 16'h03FF;
			exp[a[9:0]] = 16'($random(seed));
			psram_host_inst.async_wr(a, exp[a[9:0]], 2'h0);
			v = 16'($random(seed));
			ln = (i == 0) ? 2'h3 : 2'($random(seed));
			psram_host_inst.async_wr(a, v, ln);
			exp[a[9:0]] = merge(exp[a[9:0]], v, ln);
			psram_host_inst.async_rd(a, d);
			`CHK("async_data", exp[a[9:0]], d)
		end
		burst_chk(10'h010, 16'h5409, 1'b1);
		`CHK("first_rise", 4, first)
		burst_chk(10'h3FE, 16'h1008, 1'b0);
		`CHK("row_wait", 1'b1, last > first + 3)
		test_done();
	end
endmodule : muxed_psram_bus_interface_test
`default_nettype wire
